// file: hw/halt_sub_pkg.sv
// Constants, opcodes, register map and carrier types for the halt / subtract / nibble-swap executor.
// Assumes a classic Wishbone master with an 8-bit byte address and 32-bit data.
package halt_sub_pkg;

  // ****************************************
  // Data path widths
  // ****************************************
  localparam int DATA_W = 8;
  localparam int INSTR_W = 12;
  localparam int ADR_W = 8;
  localparam int FILE_IDX_W = 5;
  localparam int FILE_DEPTH = 32;
  localparam int NIB_W = 4;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [INSTR_W-1:0] OP_HALT = 12'h003;
  localparam logic [5:0] OP_SUB_TOP = 6'h02;
  localparam logic [5:0] OP_SWAP_TOP = 6'h0e;
  localparam int OP_TOP_LSB = 6;
  localparam int OP_DEST_BIT = 5;

  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam logic [ADR_W-1:0] ADDR_INSTR = 8'h00;
  localparam logic [ADR_W-1:0] ADDR_WORK = 8'h04;
  localparam logic [ADR_W-1:0] ADDR_STATUS = 8'h08;
  localparam logic [ADR_W-1:0] ADDR_WDOG = 8'h0c;
  localparam int FILE_SEL_BIT = 7;
  localparam int WORD_LSB = 2;

  // ****************************************
  // Status field positions
  // ****************************************
  localparam int ST_CARRY = 0;
  localparam int ST_ZERO = 1;
  localparam int ST_PD_N = 3;
  localparam int ST_TO_N = 4;
  localparam int ST_HALTED = 5;
  localparam int ST_WAKE = 6;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [INSTR_W-1:0] RST_INSTR = 12'h000;
  localparam logic [DATA_W-1:0] WDOG_CLEAR = 8'h00;
  localparam logic [DATA_W-1:0] WDOG_STEP = 8'h01;
  localparam logic [DATA_W-1:0] WDOG_WRAP = 8'hff;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_HALT,
    KIND_SUB,
    KIND_SWAP
  } kind_type;

  typedef enum logic {
    RUNNING,
    HALTED
  } core_state_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_type;

  typedef struct packed {
    logic carry;
    logic zero;
    logic pd_n;
    logic to_n;
  } flags_type;

  typedef struct packed {
    kind_type kind;
    logic to_file;
    logic [DATA_W-1:0] result;
    logic carry;
    logic zero;
  } exec_type;

endpackage : halt_sub_pkg

// file: hw/exec_alu.sv
// Combinational decoder and arithmetic for one instruction word.
// Assumes the caller supplies the addressed file byte and the working register.
`timescale 1ns/1ps
module exec_alu (
  input wire logic [halt_sub_pkg::INSTR_W-1:0] instr_i,
  input wire logic [halt_sub_pkg::DATA_W-1:0] file_i,
  input wire logic [halt_sub_pkg::DATA_W-1:0] work_i,
  output halt_sub_pkg::exec_type exec_o
);

  logic [halt_sub_pkg::DATA_W:0] diff;
  logic [5:0] top;

  // ****************************************
  // Decode and compute
  // ****************************************
  // One extra bit keeps the borrow of the subtraction
  always_comb
  begin
    top = instr_i[halt_sub_pkg::INSTR_W-1:halt_sub_pkg::OP_TOP_LSB];
    diff = {1'b0, file_i} - {1'b0, work_i};
    exec_o.kind = halt_sub_pkg::KIND_NONE;
    exec_o.to_file = instr_i[halt_sub_pkg::OP_DEST_BIT];
    exec_o.result = file_i;
    exec_o.carry = ~diff[halt_sub_pkg::DATA_W];
    exec_o.zero = (diff[halt_sub_pkg::DATA_W-1:0] == halt_sub_pkg::RST_BYTE);
    if (instr_i == halt_sub_pkg::OP_HALT)
    begin
      exec_o.kind = halt_sub_pkg::KIND_HALT;
    end
    else if (top == halt_sub_pkg::OP_SUB_TOP)
    begin
      exec_o.kind = halt_sub_pkg::KIND_SUB;
      exec_o.result = diff[halt_sub_pkg::DATA_W-1:0];
    end
    else if (top == halt_sub_pkg::OP_SWAP_TOP)
    begin
      exec_o.kind = halt_sub_pkg::KIND_SWAP;
      exec_o.result = {file_i[halt_sub_pkg::NIB_W-1:0],
                       file_i[halt_sub_pkg::DATA_W-1:halt_sub_pkg::NIB_W]};
    end
  end

endmodule : exec_alu

// file: hw/wb_slave.sv
// Classic Wishbone slave front end: registered ack and read data, write strobe.
// Assumes one outstanding request; the master holds it until it sees ack.
`timescale 1ns/1ps
module wb_slave (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input halt_sub_pkg::wb_req_type req_i,
  input wire logic [31:0] rd_data_i,
  output logic wr_stb_o,
  output logic ack_o,
  output logic [31:0] dat_o
);

  logic ack_d;
  logic ack_q;
  logic [31:0] dat_d;
  logic [31:0] dat_q;
  logic take;

  // ****************************************
  // Next state
  // ****************************************
  // Ack drops after one cycle so a held request is taken only once
  always_comb
  begin
    take = req_i.cyc & req_i.stb & ~ack_q;
    ack_d = take;
    dat_d = dat_q;
    if (take & ~req_i.we)
    begin
      dat_d = rd_data_i;
    end
    wr_stb_o = take & req_i.we & req_i.sel[0];
  end

  // Registers only
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      ack_q <= 1'b0;
      dat_q <= halt_sub_pkg::RD_ZERO;
    end
    else
    begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

endmodule : wb_slave

// file: hw/halt_sub_nibswap_exec.sv
// Executor for the halt, subtract-work-from-file and nibble-swap instructions.
// Assumes a Wishbone master that writes instruction words and reads back state.
// Assumes one clock and a synchronous, active-low reset; the watchdog has no time-out action here.
// How it works
// - Halt clears watchdog counter and its prescaler
// - Halt sets the time-out flag to one
// - Halt clears the power-down flag to zero
// - Halt stops oscillator, single word, one cycle
// - Subtract computes file minus work register
// - Subtract destination bit picks work or file
// - Swap exchanges nibbles, flags stay unchanged
// - Swap destination bit picks work or file
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module halt_sub_nibswap_exec (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input halt_sub_pkg::wb_req_type wb_req_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic halted_o,
  output logic osc_enable_o
);

  // ****************************************
  // Storage
  // ****************************************
  logic [halt_sub_pkg::DATA_W-1:0] file_q [halt_sub_pkg::FILE_DEPTH];
  logic [halt_sub_pkg::DATA_W-1:0] file_d [halt_sub_pkg::FILE_DEPTH];
  logic [halt_sub_pkg::DATA_W-1:0] work_q;
  logic [halt_sub_pkg::DATA_W-1:0] work_d;
  logic [halt_sub_pkg::INSTR_W-1:0] instr_q;
  logic [halt_sub_pkg::INSTR_W-1:0] instr_d;
  halt_sub_pkg::flags_type flags_q;
  halt_sub_pkg::flags_type flags_d;
  halt_sub_pkg::core_state_type state_q;
  halt_sub_pkg::core_state_type state_d;
  logic [halt_sub_pkg::DATA_W-1:0] watchdog_counter_q;
  logic [halt_sub_pkg::DATA_W-1:0] watchdog_counter_d;
  logic [halt_sub_pkg::DATA_W-1:0] prescale_q;
  logic [halt_sub_pkg::DATA_W-1:0] prescale_d;
  logic osc_q;
  logic osc_d;
  // Halt indication kept in its own flop so the pin is a clean register output
  logic halted_q;
  logic halted_d;

  // ****************************************
  // Bus decode
  // ****************************************
  logic wr_stb;
  logic [31:0] rd_data;
  logic [halt_sub_pkg::DATA_W-1:0] wr_byte;
  logic [halt_sub_pkg::FILE_IDX_W-1:0] bus_idx;
  logic bus_file;
  logic [halt_sub_pkg::INSTR_W-1:0] new_instr;
  logic [halt_sub_pkg::FILE_IDX_W-1:0] op_idx;
  logic issue;
  logic wake;
  halt_sub_pkg::exec_type exec;

  // Field extraction shared by all processes
  assign wr_byte = wb_req_i.dat[halt_sub_pkg::DATA_W-1:0];
  assign bus_file = wb_req_i.adr[halt_sub_pkg::FILE_SEL_BIT];
  assign bus_idx = wb_req_i.adr[halt_sub_pkg::WORD_LSB +: halt_sub_pkg::FILE_IDX_W];
  // Bits 11:8 come from byte lane 1; without that lane the old upper bits stay,
  // so an opcode with the same upper nibble can be re-issued by a byte write
  assign new_instr = {wb_req_i.sel[1] ? wb_req_i.dat[11:8] : instr_q[11:8], wr_byte};
  assign op_idx = new_instr[halt_sub_pkg::FILE_IDX_W-1:0];
  // Instructions are ignored while halted, the core clock being stopped
  assign issue = wr_stb & ~bus_file & (wb_req_i.adr == halt_sub_pkg::ADDR_INSTR) & (state_q == halt_sub_pkg::RUNNING);
  assign wake = wr_stb & ~bus_file & (wb_req_i.adr == halt_sub_pkg::ADDR_STATUS) & wr_byte[halt_sub_pkg::ST_WAKE];

  // Bus front end: one registered ack per request, read data captured on the taking edge.
  // One wait state from the registered ack, so every access costs two cycles plus the idle gap.
  wb_slave u_wb_slave (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .req_i(wb_req_i),
    .rd_data_i(rd_data),
    .wr_stb_o(wr_stb),
    .ack_o(wb_ack_o),
    .dat_o(wb_dat_o)
  );

  // The operand is read straight from the bus word so execution takes one cycle
  // The decoder is purely combinational; its result is used only while issue is high
  exec_alu u_exec_alu (
    .instr_i(new_instr),
    .file_i(file_q[op_idx]),
    .work_i(work_q),
    .exec_o(exec)
  );

  // ****************************************
  // Read mux
  // ****************************************
  // Unmapped addresses read as zero and are still acknowledged
  // The mux looks at the live address, so the slave captures it on the taking edge;
  // reading later would see the bus already released
  // The wake bit of status is write-only and reads back as zero
  always_comb
  begin
    rd_data = halt_sub_pkg::RD_ZERO;
    if (bus_file)
    begin
      rd_data[halt_sub_pkg::DATA_W-1:0] = file_q[bus_idx];
    end
    else
    begin
      case (wb_req_i.adr)
        halt_sub_pkg::ADDR_INSTR: rd_data[halt_sub_pkg::INSTR_W-1:0] = instr_q;
        halt_sub_pkg::ADDR_WORK: rd_data[halt_sub_pkg::DATA_W-1:0] = work_q;
        halt_sub_pkg::ADDR_STATUS:
        begin
          rd_data[halt_sub_pkg::ST_CARRY] = flags_q.carry;
          rd_data[halt_sub_pkg::ST_ZERO] = flags_q.zero;
          rd_data[halt_sub_pkg::ST_PD_N] = flags_q.pd_n;
          rd_data[halt_sub_pkg::ST_TO_N] = flags_q.to_n;
          rd_data[halt_sub_pkg::ST_HALTED] = (state_q == halt_sub_pkg::HALTED);
        end
        halt_sub_pkg::ADDR_WDOG: rd_data[15:0] = {prescale_q, watchdog_counter_q};
        default: rd_data = halt_sub_pkg::RD_ZERO;
      endcase
    end
  end

  // ****************************************
  // Working register, file bank, instruction latch
  // ****************************************
  // Bus writes first, then instruction results; both cannot hit in one cycle
  // because the bus carries either a data write or an instruction word, never both.
  // Subtract and swap share the destination bit, so one write-back path serves both.
  always_comb
  begin
    work_d = work_q;
    instr_d = instr_q;
    for (int i = 0; i < halt_sub_pkg::FILE_DEPTH; i++)
    begin
      file_d[i] = file_q[i];
    end
    if (wr_stb & bus_file)
    begin
      file_d[bus_idx] = wr_byte;
    end
    else if (wr_stb & (wb_req_i.adr == halt_sub_pkg::ADDR_WORK))
    begin
      work_d = wr_byte;
    end
    if (issue)
    begin
      instr_d = new_instr;
      if ((exec.kind == halt_sub_pkg::KIND_SUB) || (exec.kind == halt_sub_pkg::KIND_SWAP))
      begin
        if (exec.to_file)
        begin
          file_d[op_idx] = exec.result;
        end
        else
        begin
          work_d = exec.result;
        end
      end
    end
  end

  // Per-entry storage, one flop group each
  // Synchronous reset clears every entry, so no entry is undefined after power-up
  generate
    for (genvar g = 0; g < halt_sub_pkg::FILE_DEPTH; g++)
    begin : g_file
      always_ff @(posedge ref_clk_i)
      begin
        if (!resetn_i)
        begin
          file_q[g] <= halt_sub_pkg::RST_BYTE;
        end
        else
        begin
          file_q[g] <= file_d[g];
        end
      end
    end
  endgenerate

  // Working register and last executed instruction
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      work_q <= halt_sub_pkg::RST_BYTE;
      instr_q <= halt_sub_pkg::RST_INSTR;
    end
    else
    begin
      work_q <= work_d;
      instr_q <= instr_d;
    end
  end

  // ****************************************
  // Status flags and halt state
  // ****************************************
  // Swap falls through with flags untouched
  // A halt seen while already halted never gets here: the issue gate drops it
  always_comb
  begin
    flags_d = flags_q;
    state_d = state_q;
    osc_d = osc_q;
    case (state_q)
      halt_sub_pkg::RUNNING:
      begin
        if (issue && (exec.kind == halt_sub_pkg::KIND_HALT))
        begin
          flags_d.to_n = 1'b1;
          flags_d.pd_n = 1'b0;
          state_d = halt_sub_pkg::HALTED;
          osc_d = 1'b0;
        end
        else if (issue && (exec.kind == halt_sub_pkg::KIND_SUB))
        begin
          flags_d.carry = exec.carry;
          flags_d.zero = exec.zero;
        end
      end
      // Only the status wake bit brings the core back; no other event is modelled
      halt_sub_pkg::HALTED:
      begin
        if (wake)
        begin
          state_d = halt_sub_pkg::RUNNING;
          osc_d = 1'b1;
        end
      end
      default:
      begin
        state_d = halt_sub_pkg::RUNNING;
        osc_d = 1'b1;
      end
    endcase
    // The pin follows the next state so it rises on the same edge as the state register
    halted_d = (state_d == halt_sub_pkg::HALTED);
  end

  // Power-up: both status bits read one
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      flags_q <= '{carry: 1'b0, zero: 1'b0, pd_n: 1'b1, to_n: 1'b1};
      state_q <= halt_sub_pkg::RUNNING;
      osc_q <= 1'b1;
      halted_q <= 1'b0;
    end
    else
    begin
      flags_q <= flags_d;
      state_q <= state_d;
      osc_q <= osc_d;
      halted_q <= halted_d;
    end
  end

  // Both pins come straight from flops
  assign halted_o = halted_q;
  assign osc_enable_o = osc_q;

  // ****************************************
  // Watchdog counter and prescaler
  // ****************************************
  // Runs on its own regardless of halt; the halt clear wins over the count
  // Clearing the prescaler too means the next count comes a whole prescaler period later
  always_comb
  begin
    prescale_d = prescale_q + halt_sub_pkg::WDOG_STEP;
    watchdog_counter_d = watchdog_counter_q;
    if (prescale_q == halt_sub_pkg::WDOG_WRAP)
    begin
      watchdog_counter_d = watchdog_counter_q + halt_sub_pkg::WDOG_STEP;
    end
    if (issue && (exec.kind == halt_sub_pkg::KIND_HALT))
    begin
      prescale_d = halt_sub_pkg::WDOG_CLEAR;
      watchdog_counter_d = halt_sub_pkg::WDOG_CLEAR;
    end
  end

  // Registers only; the count wraps silently
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      prescale_q <= halt_sub_pkg::WDOG_CLEAR;
      watchdog_counter_q <= halt_sub_pkg::WDOG_CLEAR;
    end
    else
    begin
      prescale_q <= prescale_d;
      watchdog_counter_q <= watchdog_counter_d;
    end
  end

endmodule : halt_sub_nibswap_exec

// file: dv/halt_sub_assertions.sv
// Port checker for the halt / subtract / nibble-swap executor.
// Assumes a classic Wishbone master that holds each request until it sees ack.
`timescale 1ns/1ps
module halt_sub_assertions (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input halt_sub_pkg::wb_req_type wb_req_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic halted_o,
  input wire logic osc_enable_o
);
  // ****************************************
  // Decoded bus events
  // ****************************************
  logic take, wr, halt_wr, wake_wr, st_rd, wd_rd, seen_q, seen_d;
  logic [7:0] since_q, since_d;
  // A request counts only while ack is low
  assign take = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
  assign wr = take && wb_req_i.we && wb_req_i.sel[0];
  assign halt_wr = wr && wb_req_i.adr == halt_sub_pkg::ADDR_INSTR && wb_req_i.sel[1]
    && wb_req_i.dat[11:0] == halt_sub_pkg::OP_HALT && !halted_o;
  assign wake_wr = wr && wb_req_i.adr == halt_sub_pkg::ADDR_STATUS && wb_req_i.dat[halt_sub_pkg::ST_WAKE];
  // Read data is judged in the ack cycle, address still held
  assign st_rd = wb_ack_o && !wb_req_i.we && wb_req_i.adr == halt_sub_pkg::ADDR_STATUS;
  assign wd_rd = wb_ack_o && !wb_req_i.we && wb_req_i.adr == halt_sub_pkg::ADDR_WDOG;
  // Cycles since the last halt; saturates so stale halts stop counting
  always_comb
  begin
    seen_d = seen_q | halt_wr;
    since_d = halt_wr ? 8'h00 : (since_q == 8'hff ? since_q : since_q + 8'h01);
  end
  always_ff @(posedge ref_clk_i)
  begin
    seen_q <= resetn_i ? seen_d : 1'b0;
    since_q <= resetn_i ? since_d : 8'hff;
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_ack_once; wb_ack_o ##1 !wb_ack_o; endsequence
  sequence s_asleep; halted_o && !osc_enable_o; endsequence
  property p_ack_pulse; take |=> s_ack_once; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a single pulse");
  property p_halt_enter; halt_wr |=> s_asleep; endproperty
  a_halt_enter: assert property (p_halt_enter) else $error("halt not entered");
  property p_halt_cause; $rose(halted_o) |-> $past(halt_wr); endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("halt without halt word");
  property p_osc_off; halted_o != osc_enable_o; endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator runs while halted");
  property p_stay; halted_o && !wake_wr |=> halted_o; endproperty
  a_stay: assert property (p_stay) else $error("halt left without wake");
  property p_to_flag; st_rd |-> wb_dat_o[halt_sub_pkg::ST_TO_N]; endproperty
  a_to_flag: assert property (p_to_flag) else $error("time-out flag low");
  property p_pd_flag; st_rd |-> wb_dat_o[halt_sub_pkg::ST_PD_N] == !seen_q; endproperty
  a_pd_flag: assert property (p_pd_flag) else $error("power-down flag wrong");
  property p_wdog_clear;
    wd_rd && seen_q && since_q < 8'hc8 |-> wb_dat_o[7:0] == 8'h00 && wb_dat_o[15:8] <= since_q;
  endproperty
  a_wdog_clear: assert property (p_wdog_clear) else $error("watchdog not cleared");
endmodule : halt_sub_assertions

bind halt_sub_nibswap_exec halt_sub_assertions u_chk (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
  .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .halted_o(halted_o),
  .osc_enable_o(osc_enable_o));

// file: dv/tb_top.sv
// Self-checking bench for the halt / subtract / nibble-swap executor.
// Assumes one ack pulse per Wishbone access and the package's register map.
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_i;
  logic resetn_i;
  halt_sub_pkg::wb_req_type req;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  logic halted_o;
  logic osc_enable_o;
  logic [31:0] q;
  logic [11:0] near [4] = '{12'h002, 12'h013, 12'h103, 12'h803};
  int fails;
  int checked;
  halt_sub_nibswap_exec dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .wb_req_i(req),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .halted_o(halted_o), .osc_enable_o(osc_enable_o));
  // ****************************************
  // Clock, verdict and bus tasks
  // ****************************************
  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task complete_run;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask : check
  // Holds the request until ack is sampled, then releases it; a wait with no ack is ended only by the time limit
  task access(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    do
    begin
      @(posedge ref_clk_i);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask : access
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    access(1'b1, a, d, r);
  endtask : wr
  task rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    access(1'b0, a, 32'h0, r);
    check(name, exp, r);
  endtask : rd
  task op(input logic [11:0] i);
    wr(halt_sub_pkg::ADDR_INSTR, {20'h0, i});
  endtask : op
  function automatic logic [7:0] fa(input logic [4:0] i);
    return {1'b1, i, 2'b00};
  endfunction : fa
  // A hang counts as a mismatch
  initial
  begin
    #500000;
    fails++;
    complete_run;
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    resetn_i <= 1'b0;
    req <= '0;
    fails = 0;
    checked = 0;
    repeat (12) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rd("status", halt_sub_pkg::ADDR_STATUS, 32'h18);
    rd("unmapped", 8'h10, 32'h0);
    // Subtract into work: 3 - 2
    wr(halt_sub_pkg::ADDR_WORK, 32'h2);
    wr(fa(3), 32'h3);
    op(12'h083);
    rd("work", halt_sub_pkg::ADDR_WORK, 32'h1);
    rd("file3", fa(3), 32'h3);
    rd("status", halt_sub_pkg::ADDR_STATUS, 32'h19);
    // Subtract into file, equal operands give zero
    wr(fa(4), 32'h1);
    op(12'h0a4);
    rd("file4", fa(4), 32'h0);
    rd("work", halt_sub_pkg::ADDR_WORK, 32'h1);
    rd("status", halt_sub_pkg::ADDR_STATUS, 32'h1b);
    // Swap both ways; flags must survive
    wr(fa(5), 32'ha5);
    op(12'h385);
    rd("work", halt_sub_pkg::ADDR_WORK, 32'h5a);
    rd("file5", fa(5), 32'ha5);
    op(12'h3a5);
    rd("file5", fa(5), 32'h5a);
    rd("status", halt_sub_pkg::ADDR_STATUS, 32'h1b);
    // Borrow at the top file address: 01 - 5a
    wr(fa(31), 32'h1);
    op(12'h0bf);
    rd("file31", fa(31), 32'ha7);
    rd("status", halt_sub_pkg::ADDR_STATUS, 32'h18);
    // Words close to the halt pattern must not halt
    foreach (near[k])
    begin
      op(near[k]);
      check("halted", 32'h0, {31'h0, halted_o});
    end
    rd("instr", halt_sub_pkg::ADDR_INSTR, 32'h803);
    // Let the watchdog count past one prescaler wrap first
    repeat (600) @(posedge ref_clk_i);
    op(halt_sub_pkg::OP_HALT);
    check("halted", 32'h1, {31'h0, halted_o});
    check("osc", 32'h0, {31'h0, osc_enable_o});
    rd("status", halt_sub_pkg::ADDR_STATUS, 32'h30);
    access(1'b0, halt_sub_pkg::ADDR_WDOG, 32'h0, q);
    check("wdog", 32'h0, q & 32'hfffff0ff);
    // Instructions are ignored while halted, wake resumes
    op(12'h083);
    rd("work", halt_sub_pkg::ADDR_WORK, 32'h5a);
    rd("instr", halt_sub_pkg::ADDR_INSTR, 32'h3);
    wr(halt_sub_pkg::ADDR_STATUS, 32'h40);
    check("osc", 32'h1, {31'h0, osc_enable_o});
    rd("status", halt_sub_pkg::ADDR_STATUS, 32'h10);
    complete_run;
  end
endmodule : tb_top
